// File: inc/pin_edge_if.sv
`timescale 1ns/1ps
interface pin_edge_if;

  // one-cycle pulses, one per rising edge of each pin clock
  logic shift_rise;
  logic store_rise;

  modport src (
    output shift_rise,
    output store_rise
  );

  modport dst (
    input shift_rise,
    input store_rise
  );

endinterface : pin_edge_if

// File: inc/shift_store_pkg.sv
package shift_store_pkg;

  // stage count of both registers
  localparam int unsigned STAGE_COUNT = 8;
  // stage that takes the serial input on a shift
  localparam int unsigned FIRST_STAGE = 0;
  // value of a cleared register
  localparam logic [STAGE_COUNT-1:0] CLEAR_VALUE = 8'h00;
  // level of a clock pin sampled before the first edge
  localparam logic PIN_IDLE = 1'h0;
  // serial output level while the shift register is cleared
  localparam logic SERIAL_CLEAR = 1'h0;
  // system clock period in ns
  localparam int unsigned REF_CLK_PERIOD_NS = 50;

endpackage : shift_store_pkg

// File: testbench/host_pins.sv
`timescale 1ns/1ps
module host_pins (
  input wire logic sh_i,
  input wire logic d_i,
  output logic sd_o
);
  // data only valid with the clock
  assign sd_o = sh_i ? d_i : ~d_i;
endmodule : host_pins

// File: testbench/shift_store_monitor.sv
`timescale 1ns/1ps
module shift_store_monitor (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic shift_clk_i,
  input wire logic store_clk_i,
  input wire logic shift_clear_n_i,
  input wire logic store_clear_n_i,
  input wire logic serial_out_o,
  input wire logic [7:0] par_out_o
);
  wire a = shift_clk_i, b = store_clk_i, q = serial_out_o;
  wire c = shift_clear_n_i, e = store_clear_n_i;
  wire [7:0] p = par_out_o;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_q_low: assert property (!c |=> !q) else $error("q high");
  a_p_low: assert property (!e |=> p == 8'h00) else $error("p high");
  a_p_hold: assert property (e && !$rose(b) |=> $stable(p))
    else $error("p moved");
  a_q_hold: assert property (c && !$rose(a) |=> $stable(q))
    else $error("q moved");
  a_p_empty: assert property ($rose(b) && e && !c |=> p == 8'h00)
    else $error("p not empty");
  a_p_load: assert property ($rose(b) && e && c && !$rose(a)
    |=> p[7] == q) else $error("p not loaded");
  a_p_lag: assert property ($rose(a) && $rose(b) && c && e
    |=> p[7] == $past(q)) else $error("p lag");
  a_q_rise: assert property ($rose(q) |-> $past(a) && !$past(a, 2))
    else $error("q rose");
endmodule : shift_store_monitor

// File: testbench/shift_store_reg_tb.sv
`timescale 1ns/1ps
module shift_store_reg_tb;
  logic clk = 1'h0, rst = 1'h1, sh = 1'h0, st = 1'h0, d = 1'h0;
  logic cs = 1'h1, ct = 1'h1, so, sd;
  logic [7:0] po, sr = 8'h00, pr = 8'h00;
  int n_errors = 0, checks_done = 0, seed = 69, i;
  always #25 clk = ~clk;
  host_pins u_host (.sh_i(sh), .d_i(d), .sd_o(sd));
  shift_store_reg u_dut (.ref_clk_i(clk), .sys_rst_i(rst), .serial_in_i(sd),
    .shift_clk_i(sh), .store_clk_i(st), .shift_clear_n_i(cs),
    .store_clear_n_i(ct), .serial_out_o(so), .par_out_o(po));
  task chk(string n, logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [7:0] next_par(logic [7:0] p, s, logic b, x, y);
    if (!y) return 8'h00;
    if (!b) return p;
    return x ? s : 8'h00;
  endfunction : next_par
  function automatic logic [7:0] next_sr(logic [7:0] s, logic a, c, x);
    if (!x) return 8'h00;
    return a ? {s[6:0], c} : s;
  endfunction : next_sr
  task op(logic a, b, c, x, y);
    @(negedge clk);
    {sh, st, d, cs, ct} = {a, b, c, x, y};
    pr = next_par(pr, sr, b, x, y);
    sr = next_sr(sr, a, c, x);
    @(negedge clk);
    {sh, st} = 2'h0;
    chk("par", po, pr);
    chk("ser", {7'h00, so}, {7'h00, sr[7]});
  endtask : op
  task results();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (2000) @(posedge clk);
    n_errors++;
    results();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'h0;
    for (i = 0; i < 8; i++) op(1'h1, 1'h0, 1'h1, 1'h1, 1'h1);
    op(1'h0, 1'h1, 1'h0, 1'h1, 1'h1);
    op(1'h0, 1'h1, 1'h0, 1'h0, 1'h1);
    for (i = 0; i < 300; i++) op($random(seed), $random(seed), $random(seed),
      $random(seed) % 6 != 0, $random(seed) % 6 != 0);
    results();
  end
endmodule : shift_store_reg_tb
bind shift_store_reg shift_store_monitor u_mon (.ref_clk_i, .sys_rst_i,
  .shift_clk_i, .store_clk_i, .shift_clear_n_i, .store_clear_n_i,
  .serial_out_o, .par_out_o);

// File: verilog/pin_rise_detect.sv
`timescale 1ns/1ps
module pin_rise_detect (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic shift_clk_i,
  input wire logic store_clk_i,
  pin_edge_if.src edges
);

  logic shift_last;
  logic store_last;

  ////////////////////////////////////////////////////////////////////////////
  // previous pin levels
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      shift_last <= shift_store_pkg::PIN_IDLE;
      store_last <= shift_store_pkg::PIN_IDLE;
    end else begin
      shift_last <= shift_clk_i;
      store_last <= store_clk_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low-to-high transitions only
  assign edges.shift_rise = shift_clk_i & ~shift_last;
  assign edges.store_rise = store_clk_i & ~store_last;

endmodule : pin_rise_detect

// File: verilog/shift_store_reg.sv
`timescale 1ns/1ps
// Contract
// - eight shift stages, eight storage bits
// - shift on shift clock rise, clear high
// - serial input into stage zero, rest move up
// - serial output shows last shift stage
// - store clock rise loads all stages
// - parallel outputs follow storage register
// - simultaneous edges store pre-shift contents
// - tied clocks keep shift one ahead
// - shift clear zeros stages, storage untouched
// - store clear zeros storage, shift untouched
// - store during shift clear loads zeros
module shift_store_reg #(
  parameter int unsigned WIDTH = shift_store_pkg::STAGE_COUNT
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic serial_in_i,
  input wire logic shift_clk_i,
  input wire logic store_clk_i,
  input wire logic shift_clear_n_i,
  input wire logic store_clear_n_i,
  output logic serial_out_o,
  output logic [WIDTH-1:0] par_out_o
);

  // cleared value at this register width
  localparam logic [WIDTH-1:0] CLEARED =
    WIDTH'(shift_store_pkg::CLEAR_VALUE);
  // stage that drives the serial output
  localparam int unsigned LAST_STAGE = WIDTH - 1;

  // what a register does at one system clock edge
  typedef enum logic [1:0] {
    HOLD = 2'h0,
    LOAD = 2'h1,
    ZERO = 2'h3
  } act_t;

  logic [WIDTH-1:0] stages;
  logic [WIDTH-1:0] storage;
  act_t shift_act;
  act_t store_act;

  pin_edge_if edges ();

  ////////////////////////////////////////////////////////////////////////////
  // pin clock edges as one-cycle enables

  pin_rise_detect u_rise (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .shift_clk_i (shift_clk_i),
    .store_clk_i (store_clk_i),
    .edges (edges)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shared decoding

  // a clear, system or pin, beats an edge in the same cycle
  function automatic act_t reg_action(
    input logic rst,
    input logic clear_n,
    input logic rise
  );
    act_t act;
    if (rst || !clear_n) begin
      act = ZERO;
    end else if (rise) begin
      act = LOAD;
    end else begin
      act = HOLD;
    end
    return act;
  endfunction : reg_action

  // value a shift stage takes at a shift
  function automatic logic stage_source(
    input logic [WIDTH-1:0] cur,
    input logic din,
    input int unsigned idx
  );
    logic src;
    if (idx == shift_store_pkg::FIRST_STAGE) begin
      src = din;
    end else begin
      src = cur[idx-1];
    end
    return src;
  endfunction : stage_source

  // value a storage bit takes at a store: the stage as it stood
  // before this edge, or zero while the shift clear empties it
  function automatic logic store_source(
    input logic [WIDTH-1:0] cur,
    input logic clear_n,
    input int unsigned idx
  );
    logic src;
    if (clear_n) begin
      src = cur[idx];
    end else begin
      src = CLEARED[idx];
    end
    return src;
  endfunction : store_source

  ////////////////////////////////////////////////////////////////////////////
  // what each register does this cycle

  assign shift_act = reg_action(
    sys_rst_i,
    shift_clear_n_i,
    edges.shift_rise
  );

  assign store_act = reg_action(
    sys_rst_i,
    store_clear_n_i,
    edges.store_rise
  );

  ////////////////////////////////////////////////////////////////////////////
  // one slice per stage: shift stage and the storage bit above it

  for (genvar g = 0; g < WIDTH; g++) begin : g_slice

    // shift stage
    always_ff @(posedge ref_clk_i) begin
      case (shift_act)
        ZERO: begin
          stages[g] <= CLEARED[g];
        end
        LOAD: begin
          stages[g] <= stage_source(
            stages,
            serial_in_i,
            g
          );
        end
        default: begin
          stages[g] <= stages[g];
        end
      endcase
    end

    // storage bit, fed from the pre-edge stage content
    always_ff @(posedge ref_clk_i) begin
      case (store_act)
        ZERO: begin
          storage[g] <= CLEARED[g];
        end
        LOAD: begin
          storage[g] <= store_source(
            stages,
            shift_clear_n_i,
            g
          );
        end
        default: begin
          storage[g] <= storage[g];
        end
      endcase
    end

  end : g_slice

  ////////////////////////////////////////////////////////////////////////////
  // serial output: its own copy of the last stage, for cascading

  always_ff @(posedge ref_clk_i) begin
    case (shift_act)
      ZERO: begin
        serial_out_o <= shift_store_pkg::SERIAL_CLEAR;
      end
      LOAD: begin
        serial_out_o <= stage_source(
          stages,
          serial_in_i,
          LAST_STAGE
        );
      end
      default: begin
        serial_out_o <= serial_out_o;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel outputs, straight from the storage flops

  assign par_out_o = storage;

endmodule : shift_store_reg
